/* File: sim/config_word_decoder_chk.sv */
module config_word_decoder_chk
   import config_word_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sleep_active,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic config_valid,
   input wire logic debug_pin_pair_one,
   input wire logic debug_pin_pair_two,
   input wire logic debug_pin_pair_three,
   input wire logic retention_regulator_on,
   input wire logic watchdog_enable,
   input wire logic [4:0] watchdog_run_postscale,
   input wire logic [4:0] watchdog_sleep_postscale,
   input wire logic [1:0] watchdog_window_size
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_pair_onehot: assert property (
      $onehot0({debug_pin_pair_one, debug_pin_pair_two, debug_pin_pair_three}))
      else $error("two debug pin pairs routed");
   a_ret_sleep: assert property (
      retention_regulator_on |-> $past(sleep_active)) else $error("regulator on outside sleep");
   a_run_sat: assert property (
      watchdog_run_postscale <= postscale_max) else $error("run postscale above limit");
   a_sleep_sat: assert property (
      watchdog_sleep_postscale <= postscale_max) else $error("sleep postscale above limit");
   a_settings_held: assert property (
      config_valid && $past(config_valid) |-> $stable({watchdog_enable,
      watchdog_run_postscale, watchdog_sleep_postscale, watchdog_window_size}))
      else $error("decoded setting changed");
   a_valid_hold: assert property (
      config_valid |=> config_valid) else $error("config valid dropped");
   a_ready_pulse: assert property (
      pready |=> !pready) else $error("ready longer than one cycle");
   a_ready_wait: assert property (
      psel && penable && !pready |=> pready) else $error("no answer after access");
   a_unmapped_err: assert property (
      psel && penable && !pready && paddr > decoded_status_off |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ro_write: assert property (
      psel && penable && !pready && pwrite && paddr != software_control_off
      && paddr <= decoded_status_off |=> pslverr) else $error("read-only write accepted");
endmodule : config_word_decoder_chk

bind config_word_decoder config_word_decoder_chk i_config_word_decoder_chk (.clk_sys, .rst,
   .sleep_active, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .config_valid,
   .debug_pin_pair_one, .debug_pin_pair_two, .debug_pin_pair_three, .retention_regulator_on,
   .watchdog_enable, .watchdog_run_postscale, .watchdog_sleep_postscale, .watchdog_window_size);

/* File: sim/config_word_decoder_tb.sv */
module config_word_decoder_tb
   import config_word_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst = 1'b1, sleep_active = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, nv_debug_word = 32'hFFFFFFFF;
   logic [31:0] nv_power_up_word = 32'hFFFFFFFF, nv_watchdog_word = 32'hFFFFFFFF;
   logic [31:0] prdata, d, p, w, rd;
   logic pready, pslverr, config_valid, debug_pin_pair_one, debug_pin_pair_two, er, eb;
   logic debug_pin_pair_three, boundary_scan_enable, brownout_reset, low_power_brownout_enable;
   logic retention_regulator_on, watchdog_enable, window_mode_enable;
   logic [1:0] watchdog_run_clock_select, watchdog_window_size;
   logic [4:0] watchdog_run_postscale, watchdog_sleep_postscale;
   int failures = 0, checks_done = 0;
   // Every legal code of each two-bit field appears; reserved bits stay at one.
   logic [31:0] tab [4][3] = '{'{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFF9FF},
      '{32'hFFFFFFF3, 32'hFFFFFFF2, 32'hFFFF5440}, '{32'hFFFFFFEF, 32'hFFFFFFF9, 32'hFFFF9FB3},
      '{32'hFFFFFFE3, 32'hFFFFFFFC, 32'hFFFF6014}};

   config_word_decoder i_config_word_decoder (.clk_sys, .rst, .nv_debug_word, .nv_power_up_word,
      .nv_watchdog_word, .sleep_active, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .config_valid, .debug_pin_pair_one, .debug_pin_pair_two,
      .debug_pin_pair_three, .boundary_scan_enable, .brownout_reset, .low_power_brownout_enable,
      .retention_regulator_on, .watchdog_enable, .watchdog_run_clock_select,
      .watchdog_run_postscale, .watchdog_sleep_postscale, .window_mode_enable,
      .watchdog_window_size);

   always #12.5 clk_sys = ~clk_sys;

   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   initial begin
      for (int c = 0; c < 4; c++) begin
         {d, p, w} = {tab[c][0], tab[c][1], tab[c][2]};
         {nv_debug_word, nv_power_up_word, nv_watchdog_word} <= {d, p, w};
         rst <= 1'b1;
         sleep_active <= 1'b0;
         repeat (4) @(posedge clk_sys);
         rst <= 1'b0;
         repeat (6) @(posedge clk_sys);
         chk(config_valid, 1'b1);
         chk({debug_pin_pair_one, debug_pin_pair_two, debug_pin_pair_three},
             {d[4:3] == 2'b11, d[4:3] == 2'b10, d[4:3] == 2'b01});
         chk(boundary_scan_enable, d[2]);
         chk(watchdog_enable, w[15]);
         chk(watchdog_run_clock_select, w[14:13]);
         chk(watchdog_run_postscale, (w[12:8] > 5'h13) ? 5'h14 : w[12:8]);
         chk(watchdog_sleep_postscale, (w[4:0] > 5'h13) ? 5'h14 : w[4:0]);
         chk(window_mode_enable, !w[7]);
         chk(watchdog_window_size, w[6:5]);
         // Changing the source words after capture must not reach the stored copies.
         {nv_debug_word, nv_power_up_word, nv_watchdog_word} <= {tab[(c + 1) % 4][0],
            tab[(c + 1) % 4][1], tab[(c + 1) % 4][2]};
         for (int k = 0; k < 3; k++) begin
            apb(1'b1, 12'(k * 4), 32'h0);
            chk(er, 1'b1);
            apb(1'b0, 12'(k * 4), 32'h0);
            chk(rd, tab[c][k]);
         end
         apb(1'b0, 12'h020, 32'h0);
         chk(er, 1'b1);
         chk(rd, 32'h0);
         for (int i = 0; i < 4; i++) begin
            sleep_active <= i[1];
            apb(1'b1, software_control_off, {30'h0, i[0], i[0]});
            repeat (3) @(posedge clk_sys);
            case (p[1:0])
               2'b11: eb = 1'b1;
               2'b10: eb = !i[1];
               2'b01: eb = i[0];
               default: eb = 1'b0;
            endcase
            chk(brownout_reset, eb);
            chk(low_power_brownout_enable, p[3] & !eb);
            chk(retention_regulator_on, !p[2] & i[0] & i[1]);
         end
         chk(watchdog_enable, w[15]);
         $display("test %0d done", c);
      end
      print_verdict();
   end

   // The tests need a few hundred cycles; this limit leaves a wide margin.
   initial begin
      #125000;
      failures++;
      print_verdict();
   end
endmodule : config_word_decoder_tb

/* File: src/config_word_decoder.sv */
// Overview of operation
// - Debug channel code 11/10/01 selects pin pair one/two/three; 00 leaves none.
// - Debug word bit 2 set enables boundary-scan port, clear disables it.
// - Low-power brown-out detector runs when enabled and main brown-out reset is off.
// - Retention regulator bit set disables regulator; clear lets sleep control drive it.
// - Policy 11 keeps brown-out reset always on, software bit ignored.
// - Policy 10 enables brown-out reset only while active, off in sleep.
// - Policy 01 lets software brown-out control bit alone decide.
// - Policy 00 turns brown-out reset off, software bit ignored.
// - Run clock code 11 low-power RC, 10 fast RC, 00 system clock.
// - Low-power RC run source equals the source always used in sleep.
// - Run postscale divides by two to the code, 1:1 up to 1:1048576.
// - Postscale codes 10100 to 11111 saturate at 1:1048576, run and sleep.
// - Watchdog word bit 7 set disables windowed mode, clear enables it.
// - Window size code 11/10/01/00 gives 25/37.5/50/75 percent.
// - Sleep postscale field bits 4..0 uses the same power-of-two encoding.
//
// The implementer's own choices: the register addresses and register access over APB.
module config_word_decoder
   import config_word_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [31:0] nv_debug_word,
   input wire logic [31:0] nv_power_up_word,
   input wire logic [31:0] nv_watchdog_word,
   input wire logic sleep_active,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic config_valid,
   output logic debug_pin_pair_one,
   output logic debug_pin_pair_two,
   output logic debug_pin_pair_three,
   output logic boundary_scan_enable,
   output logic brownout_reset,
   output logic low_power_brownout_enable,
   output logic retention_regulator_on,
   output logic watchdog_enable,
   output logic [1:0] watchdog_run_clock_select,
   output logic [4:0] watchdog_run_postscale,
   output logic [4:0] watchdog_sleep_postscale,
   output logic window_mode_enable,
   output logic [1:0] watchdog_window_size
);

   typedef struct packed {
      load_state_t state;
      logic [31:0] debug_word;
      logic [31:0] power_word;
      logic [31:0] wdt_word;
      logic software_brownout_control;
      logic retention_sleep_control;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic valid;
      logic pair_one;
      logic pair_two;
      logic pair_three;
      logic scan_en;
      logic bor;
      logic lp_bor;
      logic ret_on;
      logic wdt_en;
      logic [1:0] run_clk;
      logic [4:0] run_ps;
      logic [4:0] sleep_ps;
      logic win_en;
      logic [1:0] win_size;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Codes beyond the largest ratio all mean that ratio, so they are clamped here
   // rather than handed on for the watchdog to interpret.
   function automatic logic [4:0] saturate_postscale(input logic [4:0] code);
      if (code > postscale_max) begin
         return postscale_max;
      end
      return code;
   endfunction : saturate_postscale

   // Turns the channel code into one routing flag per pin pair, ordered one, two, three.
   // Code 00 leaves the debugger unconnected, so all three flags stay low.
   function automatic logic [2:0] route_debug_pairs(input logic [1:0] code);
      logic [2:0] pairs;
      pairs = 3'h0;
      case (code)
         pin_pair_one: begin
            pairs = 3'h4;
         end
         pin_pair_two: begin
            pairs = 3'h2;
         end
         pin_pair_three: begin
            pairs = 3'h1;
         end
         default: begin
            pairs = 3'h0;
         end
      endcase
      return pairs;
   endfunction : route_debug_pairs

   // Main brown-out reset for the captured policy. Only policy 01 listens to software;
   // the other three ignore the software bit, so a stale write cannot weaken them.
   function automatic logic brownout_from_policy(
      input logic [1:0] policy,
      input logic asleep,
      input logic sw_request
   );
      logic active;
      active = 1'b0;
      case (policy)
         brownout_always: begin
            active = 1'b1;
         end
         brownout_active_only: begin
            active = !asleep;
         end
         brownout_software: begin
            active = sw_request;
         end
         default: begin
            active = 1'b0;
         end
      endcase
      return active;
   endfunction : brownout_from_policy

   // The low-power detector only covers the gap left when the main detector is off.
   function automatic logic low_power_brownout_on(
      input logic lp_enable,
      input logic main_on
   );
      return lp_enable && !main_on;
   endfunction : low_power_brownout_on

   // Setting the regulator bit keeps the retention regulator off whatever software asks.
   function automatic logic retention_on(
      input logic regulator_off,
      input logic sleep_request,
      input logic asleep
   );
      return !regulator_off && sleep_request && asleep;
   endfunction : retention_on

   // The word holds a disable bit while the output is an enable.
   function automatic logic window_enabled(input logic disable_bit);
      return !disable_bit;
   endfunction : window_enabled

   // Status word: decoded settings as software sees them, bit 0 telling whether they are live.
   function automatic logic [31:0] pack_status(input state_t s);
      logic [31:0] word;
      word = {18'h00000,
         s.bor,
         s.lp_bor,
         s.ret_on,
         s.wdt_en,
         s.run_clk,
         s.win_en,
         s.win_size,
         s.scan_en,
         s.pair_one,
         s.pair_two,
         s.pair_three,
         s.valid};
      return word;
   endfunction : pack_status

   // Only the two software bits exist at this offset; the rest reads as zero.
   function automatic logic [31:0] pack_software_control(input state_t s);
      logic [31:0] word;
      word = 32'h00000000;
      word[sw_brownout_bit] = s.software_brownout_control;
      word[sw_retention_bit] = s.retention_sleep_control;
      return word;
   endfunction : pack_software_control

   // Reset leaves the words erased and every decoded output inert until the capture runs.
   function automatic state_t reset_state();
      state_t s;
      s = '0;
      s.state = load_idle;
      s.debug_word = erased_word;
      s.power_word = erased_word;
      s.wdt_word = erased_word;
      s.software_brownout_control = 1'b0;
      s.retention_sleep_control = 1'b0;
      s.rdata = 32'h00000000;
      s.ready = 1'b0;
      s.slverr = 1'b0;
      s.valid = 1'b0;
      s.pair_one = 1'b0;
      s.pair_two = 1'b0;
      s.pair_three = 1'b0;
      s.scan_en = 1'b0;
      s.bor = 1'b0;
      s.lp_bor = 1'b0;
      s.ret_on = 1'b0;
      s.wdt_en = 1'b0;
      s.run_clk = 2'h0;
      s.run_ps = 5'h00;
      s.sleep_ps = 5'h00;
      s.win_en = 1'b0;
      s.win_size = 2'h0;
      return s;
   endfunction : reset_state

   always_comb begin
      logic [1:0] channel;
      logic [1:0] policy;
      logic main_bor;
      channel = 2'b00;
      policy = 2'b00;
      main_bor = 1'b0;
      state_next = state_reg;
      state_next.ready = 1'b0;
      state_next.slverr = 1'b0;

      // Words are sampled once after reset; nothing else ever loads them.
      // The idle cycle gives the nonvolatile read path one settled cycle before capture.
      case (state_reg.state)
         load_idle: begin
            state_next.state = load_capture;
         end
         load_capture: begin
            state_next.debug_word = nv_debug_word;
            state_next.power_word = nv_power_up_word;
            state_next.wdt_word = nv_watchdog_word;
            state_next.state = load_done;
         end
         load_done: begin
            state_next.valid = 1'b1;
         end
         default: begin
            state_next.state = load_idle;
         end
      endcase

      // APB slave: one wait state, so pready rises in the second access cycle.
      // Register map: 000 debug word, 004 power-up word, 008 watchdog word, all read-only;
      // 00C software control, read-write; 010 decoded status, read-only.
      // A write to a read-only word is refused with pslverr and leaves the word alone,
      // because the words belong to the external programmer, not to software.
      if (psel && penable && !state_reg.ready) begin
         state_next.ready = 1'b1;
         state_next.rdata = 32'h00000000;
         case (paddr)
            debug_config_word_off: begin
               state_next.rdata = state_reg.debug_word;
               state_next.slverr = pwrite;
            end
            power_up_config_word_off: begin
               state_next.rdata = state_reg.power_word;
               state_next.slverr = pwrite;
            end
            watchdog_config_word_off: begin
               state_next.rdata = state_reg.wdt_word;
               state_next.slverr = pwrite;
            end
            software_control_off: begin
               if (pwrite) begin
                  state_next.software_brownout_control = pwdata[sw_brownout_bit];
                  state_next.retention_sleep_control = pwdata[sw_retention_bit];
               end
               state_next.rdata = pack_software_control(state_reg);
            end
            decoded_status_off: begin
               state_next.rdata = pack_status(state_reg);
               state_next.slverr = pwrite;
            end
            default: begin
               state_next.slverr = 1'b1;
            end
         endcase
      end

      // Decoded outputs follow the captured words, sleep_active and the software bits; they stay inert until loaded.
      channel = state_reg.debug_word[debug_channel_lsb +: 2];
      policy = state_reg.power_word[brownout_policy_lsb +: 2];
      // Decoding starts in the cycle before config_valid rises and its results register on the same edge
      // as the flag, so the flag never announces settings that still hold their reset values.
      if (state_reg.state == load_done) begin
         {state_next.pair_one, state_next.pair_two, state_next.pair_three} =
            route_debug_pairs(channel);
         state_next.scan_en = state_reg.debug_word[boundary_scan_bit];
         main_bor = brownout_from_policy(policy, sleep_active,
            state_reg.software_brownout_control);
         state_next.bor = main_bor;
         state_next.lp_bor = low_power_brownout_on(
            state_reg.power_word[low_power_brownout_bit], main_bor);
         state_next.ret_on = retention_on(state_reg.power_word[retention_regulator_bit],
            state_reg.retention_sleep_control, sleep_active);
         state_next.wdt_en = state_reg.wdt_word[watchdog_enable_bit];
         // Code 11 is the same low-power RC used in sleep; reserved 01 passes through.
         state_next.run_clk = state_reg.wdt_word[run_clock_lsb +: 2];
         state_next.run_ps = saturate_postscale(
            state_reg.wdt_word[run_postscale_lsb +: 5]);
         state_next.sleep_ps = saturate_postscale(
            state_reg.wdt_word[sleep_postscale_lsb +: 5]);
         state_next.win_en = window_enabled(state_reg.wdt_word[window_disable_bit]);
         state_next.win_size = state_reg.wdt_word[window_size_lsb +: 2];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= reset_state();
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.slverr;
   assign config_valid = state_reg.valid;
   assign debug_pin_pair_one = state_reg.pair_one;
   assign debug_pin_pair_two = state_reg.pair_two;
   assign debug_pin_pair_three = state_reg.pair_three;
   assign boundary_scan_enable = state_reg.scan_en;
   assign brownout_reset = state_reg.bor;
   assign low_power_brownout_enable = state_reg.lp_bor;
   assign retention_regulator_on = state_reg.ret_on;
   assign watchdog_enable = state_reg.wdt_en;
   assign watchdog_run_clock_select = state_reg.run_clk;
   assign watchdog_run_postscale = state_reg.run_ps;
   assign watchdog_sleep_postscale = state_reg.sleep_ps;
   assign window_mode_enable = state_reg.win_en;
   assign watchdog_window_size = state_reg.win_size;

endmodule : config_word_decoder

/* File: src/config_word_pkg.sv */
package config_word_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] debug_config_word_off = 12'h000;
   localparam logic [11:0] power_up_config_word_off = 12'h004;
   localparam logic [11:0] watchdog_config_word_off = 12'h008;
   localparam logic [11:0] software_control_off = 12'h00C;
   localparam logic [11:0] decoded_status_off = 12'h010;

   // Debug word fields.
   localparam int debug_channel_lsb = 3;
   localparam int boundary_scan_bit = 2;

   // Power-up word fields.
   localparam int low_power_brownout_bit = 3;
   localparam int retention_regulator_bit = 2;
   localparam int brownout_policy_lsb = 0;

   // Watchdog word fields.
   localparam int watchdog_enable_bit = 15;
   localparam int run_clock_lsb = 13;
   localparam int run_postscale_lsb = 8;
   localparam int window_disable_bit = 7;
   localparam int window_size_lsb = 5;
   localparam int sleep_postscale_lsb = 0;

   // Software control register fields.
   localparam int sw_brownout_bit = 0;
   localparam int sw_retention_bit = 1;

   // Largest postscale exponent; codes above saturate here.
   localparam logic [4:0] postscale_max = 5'h14;

   // Erased word value used when no programmed word is present.
   localparam logic [31:0] erased_word = 32'hFFFFFFFF;

   typedef enum logic [1:0] {
      pin_pair_none = 2'b00,
      pin_pair_three = 2'b01,
      pin_pair_two = 2'b10,
      pin_pair_one = 2'b11
   } debug_channel_t;

   typedef enum logic [1:0] {
      brownout_off = 2'b00,
      brownout_software = 2'b01,
      brownout_active_only = 2'b10,
      brownout_always = 2'b11
   } brownout_policy_t;

   typedef enum logic [1:0] {
      wdt_clk_system = 2'b00,
      wdt_clk_reserved = 2'b01,
      wdt_clk_fast_rc = 2'b10,
      wdt_clk_low_power_rc = 2'b11
   } wdt_clock_t;

   // Window size encodings: 11=25%, 10=37.5%, 01=50%, 00=75%.
   localparam logic [1:0] window_25 = 2'b11;
   localparam logic [1:0] window_37p5 = 2'b10;
   localparam logic [1:0] window_50 = 2'b01;
   localparam logic [1:0] window_75 = 2'b00;

   typedef enum logic [1:0] {
      load_idle = 2'b00,
      load_capture = 2'b01,
      load_done = 2'b10
   } load_state_t;

endpackage : config_word_pkg
